//--- vcr_pkg.sv
// Package for the channel resource register bank: offsets, fields, resets.
// Assumes a 32-bit register port with byte addresses and one-cycle read latency.
package vcr_pkg;
    localparam int          ADDR_W            = 12;
    localparam int          DATA_W            = 32;
    // Register byte addresses
    localparam logic [11:0] CAP_ADDR          = 12'h210;
    localparam logic [11:0] CTL_ADDR          = 12'h214;
    localparam logic [11:0] STS_ADDR          = 12'h218;
    // Capability fields
    localparam int          CAP_SCHEME_LSB    = 0;
    localparam int          CAP_SCHEME_W      = 8;
    localparam int          CAP_APS_BIT       = 14;
    localparam int          CAP_SNOOP_BIT     = 15;
    localparam int          CAP_MAX_TIME_SLOTS_LSB     = 16;
    localparam int          CAP_MAX_TIME_SLOTS_W       = 7;
    localparam int          CAP_OFFSET_LSB    = 24;
    localparam int          CAP_OFFSET_W      = 8;
    localparam logic [7:0]  SCHEME_CAP_UP     = 8'h03;
    localparam logic [7:0]  SCHEME_CAP_DOWN   = 8'h01;
    localparam logic [7:0]  TABLE_OFFSET_UP   = 8'h02;
    localparam logic [7:0]  TABLE_OFFSET_DOWN = 8'h00;
    localparam logic [6:0]  MAX_TIME_SLOTS    = 7'h00;
    // Control fields
    localparam int          CTL_TCMAP_LSB     = 0;
    localparam int          CTL_TCMAP_W       = 8;
    localparam logic [7:0]  TCMAP_RESET       = 8'hFF;
    localparam logic [7:0]  TCMAP_WR_MASK     = 8'hFE;
    localparam int          CTL_LOAD_BIT      = 16;
    localparam int          CTL_SEL_LSB       = 17;
    localparam int          CTL_SEL_W         = 3;
    localparam logic [2:0]  SEL_RESET         = 3'h0;
    localparam int          CTL_ID_LSB        = 24;
    localparam logic [2:0]  CHANNEL_ID        = 3'h0;
    localparam int          CTL_EN_BIT        = 31;
    localparam logic        CHANNEL_EN        = 1'b1;
    // Status fields
    localparam int          STS_TABLE_BIT     = 16;
    // Cycles the arbitration logic takes to latch the table
    localparam logic [3:0]  LOAD_CYCLES       = 4'h8;
    // Load sequencer states, Gray along idle -> copy -> done
    typedef enum logic [1:0] {
        VCR_IDLE = 2'b00,
        VCR_COPY = 2'b01,
        VCR_DONE = 2'b11
    } vcr_load_state_t;
endpackage

//--- vcr_stale_flag.sv
// Sticky flag: set by one event, cleared by another; set wins over clear.
// Assumes both inputs synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module vcr_stale_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Events
    input  wire logic set_evt,
    input  wire logic clr_evt,
    // Flag
    output var  logic flag
);
    // Set has priority so a table write during load completion is not lost
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_evt) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- vcr_load_seq.sv
// Table load sequencer: copies the table into arbitration logic over a fixed count.
// Assumes start is a one-cycle pulse already gated by port role and scheme.
`timescale 1ns/1ns
`default_nettype none
module vcr_load_seq #(
    parameter logic [3:0] CYCLES = vcr_pkg::LOAD_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic start,
    // Status
    output var  logic copy_en,
    output var  logic done
);
    vcr_pkg::vcr_load_state_t state;
    vcr_pkg::vcr_load_state_t next_state;
    logic [3:0]               count;

    // Next-state choice; a start during a copy restarts nothing, copy finishes
    always_comb begin
        next_state = state;
        case (state)
            vcr_pkg::VCR_IDLE: if (start) next_state = vcr_pkg::VCR_COPY;
            vcr_pkg::VCR_COPY: if (count == CYCLES - 4'h1) next_state = vcr_pkg::VCR_DONE;
            vcr_pkg::VCR_DONE: next_state = vcr_pkg::VCR_IDLE;
            default:           next_state = vcr_pkg::VCR_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= vcr_pkg::VCR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Copy cycle counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 4'h0;
        end else if (state == vcr_pkg::VCR_COPY) begin
            count <= count + 4'h1;
        end else begin
            count <= 4'h0;
        end
    end

    assign copy_en = (state == vcr_pkg::VCR_COPY);
    assign done    = (state == vcr_pkg::VCR_DONE);
endmodule
`default_nettype wire

//--- vcr_regs.sv
// Channel resource register bank: capability, control and table status.
// Assumes a plain register port, one-cycle read data, and one clock domain.
// How it works
// - The advanced packet switching bit of the capability register reads zero.
// - The snoop rejection bit of the capability register reads zero.
// - The seven-bit maximum time slot field reads zero.
// - The table offset reads 0x2 on the upstream port and 0x0 downstream.
// - All eight traffic class map bits are set after reset, each mapping its class.
// - Bit 0 of the traffic class map is read-only; bits 7..1 are writable.
// - Writing one to the table-load bit copies the table into arbitration logic.
// - Writing zero to the table-load bit does nothing.
// - The table-load bit acts only on the upstream port.
// - The load only acts when the selected scheme uses the table.
// - The channel identifier is hardwired zero and read-only.
// - The channel enable bit is hardwired one and read-only.
// - Table status sets on any table entry write and clears when a load finishes; zero downstream.
// - Scheme capability reads 0x3 upstream and 0x1 downstream.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module vcr_regs #(
    parameter bit UPSTREAM = 1'b1
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    // Register port
    input  wire logic [vcr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [vcr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output var  logic [vcr_pkg::DATA_W-1:0] reg_rdata,
    // Arbitration table side
    input  wire logic                       table_entry_wr,
    output var  logic                       table_copy,
    // Configuration to the arbiter
    output var  logic [7:0]                 traffic_class_map,
    output var  logic [2:0]                 arb_scheme_select
);
    logic [7:0]  tc_map;
    logic [2:0]  sel;
    logic        wr_ctl;
    logic        load_start;
    logic        copy_en;
    logic        load_done;
    logic        stale;
    logic        arb_table_status;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [7:0]  arb_scheme_capability;
    logic [7:0]  arb_table_offset;
    logic        scheme_uses_table;

    // Port-dependent constants
    assign arb_scheme_capability = UPSTREAM ? vcr_pkg::SCHEME_CAP_UP
                                            : vcr_pkg::SCHEME_CAP_DOWN;
    assign arb_table_offset      = UPSTREAM ? vcr_pkg::TABLE_OFFSET_UP
                                            : vcr_pkg::TABLE_OFFSET_DOWN;

    assign wr_ctl = reg_wr && (reg_addr == vcr_pkg::CTL_ADDR);

    // Only a non-zero select whose scheme capability bit is set (32-phase WRR, select 1, upstream) needs the load
    assign scheme_uses_table = (sel != vcr_pkg::SEL_RESET)
                               && arb_scheme_capability[sel];

    // Load fires on a written one, upstream only, table scheme only
    assign load_start = wr_ctl && reg_wdata[vcr_pkg::CTL_LOAD_BIT]
                        && UPSTREAM && scheme_uses_table;

    // Writable control fields; bit 0 of the map is kept set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tc_map <= vcr_pkg::TCMAP_RESET;
            sel    <= vcr_pkg::SEL_RESET;
        end else if (wr_ctl) begin
            tc_map <= (reg_wdata[7:0] & vcr_pkg::TCMAP_WR_MASK)
                      | (tc_map & ~vcr_pkg::TCMAP_WR_MASK);
            sel    <= reg_wdata[vcr_pkg::CTL_SEL_LSB +: vcr_pkg::CTL_SEL_W];
        end
    end

    // Load sequencer
    vcr_load_seq #(
        .CYCLES (vcr_pkg::LOAD_CYCLES)
    ) u_load (
        .clk     (ref_clk),
        .arst_n  (arst_n),
        .start   (load_start),
        .copy_en (copy_en),
        .done    (load_done)
    );

    // Table coherency flag
    vcr_stale_flag u_stale (
        .clk     (ref_clk),
        .arst_n  (arst_n),
        .set_evt (table_entry_wr),
        .clr_evt (load_done),
        .flag    (stale)
    );

    assign arb_table_status = UPSTREAM && stale;

    // Read words; fixed fields and reserved bits are constants
    always_comb begin
        cap_word = '0;
        cap_word[vcr_pkg::CAP_SCHEME_LSB +: vcr_pkg::CAP_SCHEME_W] = arb_scheme_capability;
        cap_word[vcr_pkg::CAP_APS_BIT]   = 1'b0;
        cap_word[vcr_pkg::CAP_SNOOP_BIT] = 1'b0;
        cap_word[vcr_pkg::CAP_MAX_TIME_SLOTS_LSB +: vcr_pkg::CAP_MAX_TIME_SLOTS_W] = vcr_pkg::MAX_TIME_SLOTS;
        cap_word[vcr_pkg::CAP_OFFSET_LSB +: vcr_pkg::CAP_OFFSET_W] = arb_table_offset;
        ctl_word = '0;
        ctl_word[vcr_pkg::CTL_TCMAP_LSB +: vcr_pkg::CTL_TCMAP_W] = tc_map;
        ctl_word[vcr_pkg::CTL_SEL_LSB +: vcr_pkg::CTL_SEL_W] = sel;
        ctl_word[vcr_pkg::CTL_ID_LSB +: $bits(vcr_pkg::CHANNEL_ID)] = vcr_pkg::CHANNEL_ID;
        ctl_word[vcr_pkg::CTL_EN_BIT] = vcr_pkg::CHANNEL_EN;
        sts_word = '0;
        sts_word[vcr_pkg::STS_TABLE_BIT] = arb_table_status;
    end

    // Read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                vcr_pkg::CAP_ADDR: reg_rdata <= cap_word;
                vcr_pkg::CTL_ADDR: reg_rdata <= ctl_word;
                vcr_pkg::STS_ADDR: reg_rdata <= sts_word;
                default:           reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Registered outputs to the arbiter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            table_copy        <= 1'b0;
            traffic_class_map <= vcr_pkg::TCMAP_RESET;
            arb_scheme_select <= vcr_pkg::SEL_RESET;
        end else begin
            table_copy        <= copy_en;
            traffic_class_map <= tc_map;
            arb_scheme_select <= sel;
        end
    end

    // Checks: fixed fields read as constants whatever software wrote
    a_cap_fixed: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        reg_rd && reg_addr == vcr_pkg::CAP_ADDR |=> reg_rdata[23:8] == 16'h0000
        && reg_rdata[7:0] == (UPSTREAM ? 8'h03 : 8'h01)
        && reg_rdata[31:24] == (UPSTREAM ? 8'h02 : 8'h00))
        else $error("capability word wrong");
    a_ctl_fixed: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        reg_rd && reg_addr == vcr_pkg::CTL_ADDR |=> reg_rdata[31:24] == 8'h80
        && reg_rdata[23:20] == 4'h0 && reg_rdata[16:8] == 9'h000 && reg_rdata[0])
        else $error("control fixed bits wrong");
    // Status word: only the table bit may be set, and never downstream
    a_status_word: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        reg_rd && reg_addr == vcr_pkg::STS_ADDR |=> reg_rdata[31:17] == 15'h0000
        && reg_rdata[15:0] == 16'h0000 && (UPSTREAM || !reg_rdata[16]))
        else $error("status word wrong");
    // Idle and unmapped read slots return zero
    a_rdata_zero: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !reg_rd || (reg_addr != vcr_pkg::CAP_ADDR && reg_addr != vcr_pkg::CTL_ADDR
        && reg_addr != vcr_pkg::STS_ADDR) |=> reg_rdata == 32'h00000000)
        else $error("read data outside mapped slot");
    // Map: bit 0 pinned, upper bits follow the write two edges later
    a_map_bit0: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        traffic_class_map[0])
        else $error("map bit zero cleared");
    a_map_write: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        wr_ctl |=> ##1 traffic_class_map[7:1] == $past(reg_wdata[7:1], 2))
        else $error("map write lost");
    // Load gating: zero writes, downstream and fixed round robin start nothing
    a_load_zero: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        wr_ctl && !reg_wdata[vcr_pkg::CTL_LOAD_BIT] && !copy_en |=> !copy_en)
        else $error("load started on zero");
    a_load_void: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        wr_ctl && (!UPSTREAM || sel == vcr_pkg::SEL_RESET) && !copy_en && !load_done
        |=> !copy_en)
        else $error("load started without table");
    a_load_copy: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        load_start && !copy_en && !load_done |=> copy_en [*8] ##1 load_done
        ##1 table_copy == 1'b0)
        else $error("load sequence wrong");
    // Coherency flag: set by entry writes, cleared by a finished load
    a_status_set: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        table_entry_wr |=> arb_table_status == UPSTREAM)
        else $error("status not set");
    a_status_clr: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        load_done && !table_entry_wr |=> !arb_table_status)
        else $error("status not cleared");
endmodule
`default_nettype wire

//--- vcr_regs_tb_top.sv
// Testbench for the channel resource register bank, upstream and downstream side by side.
// Assumes the one-cycle read port of the bank; both roles share every input except the write data, whose select field is masked downstream.
`timescale 1ns/1ns
`default_nettype none
module vcr_regs_tb_top;
    // Shared stimulus
    logic        ref_clk;
    logic        arst_n;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        table_entry_wr;
    // Outputs of both roles
    logic [31:0] rdata_up, rdata_dn;
    logic        copy_up, copy_dn;
    logic [7:0]  tcmap_up, tcmap_dn;
    logic [2:0]  sel_up, sel_dn;
    int          err_total = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n_up, n_dn;
    // Rows: address, upstream read, downstream read
    logic [11:0] row_a [5] = '{12'h210, 12'h214, 12'h218, 12'h21C, 12'h20C};
    logic [31:0] row_u [5] = '{32'h02000003, 32'h800000FF, 32'h00000000, 32'h00000000,
                               32'h00000000};
    logic [31:0] row_d [5] = '{32'h00000001, 32'h800000FF, 32'h00000000, 32'h00000000,
                               32'h00000000};

    vcr_regs #(.UPSTREAM(1'b1)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_up),
        .table_entry_wr(table_entry_wr), .table_copy(copy_up),
        .traffic_class_map(tcmap_up), .arb_scheme_select(sel_up));
    // Downstream software only selects fixed round robin, so its select field stays zero
    vcr_regs #(.UPSTREAM(1'b0)) dut_down (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata & 32'hFFF1FFFF),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_dn),
        .table_entry_wr(table_entry_wr), .table_copy(copy_dn),
        .traffic_class_map(tcmap_dn), .arb_scheme_select(sel_dn));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One write cycle; returns just after the edge that took it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One read cycle; data looked at only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] eu, input logic [31:0] ed);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata_up, eu);
        chk(rdata_dn, ed);
    endtask

    // Counts cycles with the copy level high in each role
    task automatic count_copy(input int cyc);
        n_up = 0;
        n_dn = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            #1;
            if (copy_up === 1'b1) n_up++;
            if (copy_dn === 1'b1) n_dn++;
        end
    endtask

    // Hang guard, well above the hundred or so cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        arst_n         = 1'b0;
        reg_addr       = 12'h000;
        reg_wdata      = 32'h00000000;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        table_entry_wr = 1'b0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(row_a[i], row_u[i], row_d[i]);
        // Ones into the identifier and reserved places, zero into the enable bit and the map
        wr(12'h214, 32'h7FF0FF00);
        // Arbiter copies are registered, so they follow one edge after the write
        @(posedge ref_clk);
        #1;
        chk({24'h000000, tcmap_up}, 32'h00000001);
        chk({24'h000000, tcmap_dn}, 32'h00000001);
        rd(12'h214, 32'h80000001, 32'h80000001);
        // Table-using scheme chosen upstream
        wr(12'h214, 32'h000200AA);
        @(posedge ref_clk);
        #1;
        chk({29'h00000000, sel_up}, 32'h00000001);
        chk({29'h00000000, sel_dn}, 32'h00000000);
        // Load bit clear while the table scheme is already held
        wr(12'h214, 32'h000200AA);
        count_copy(12);
        chk(n_up, 32'h00000000);
        rd(12'h214, 32'h800200AB, 32'h800000AB);
        // Entry write marks the table stale on the upstream role only
        @(posedge ref_clk);
        table_entry_wr <= 1'b1;
        @(posedge ref_clk);
        table_entry_wr <= 1'b0;
        rd(12'h218, 32'h00010000, 32'h00000000);
        // Load request: eight copy cycles upstream, none downstream
        wr(12'h214, 32'h000300AA);
        count_copy(20);
        chk(n_up, 32'h00000008);
        chk(n_dn, 32'h00000000);
        rd(12'h218, 32'h00000000, 32'h00000000);
        rd(12'h214, 32'h800200AB, 32'h800000AB);
        // Fixed round robin does not use the table, so a load is void
        wr(12'h214, 32'h000000AA);
        wr(12'h214, 32'h000100AA);
        count_copy(20);
        chk(n_up, 32'h00000000);
        // Second reset in mid-run restores the map
        @(posedge ref_clk);
        arst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({24'h000000, tcmap_up}, 32'h000000FF);
        chk({24'h000000, tcmap_dn}, 32'h000000FF);
        chk({29'h00000000, sel_up}, 32'h00000000);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(12'h214, 32'h800000FF, 32'h800000FF);
        report_and_stop();
    end
endmodule
`default_nettype wire
